// ---- logic/analog_output_channel_failsafe.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "ao_failsafe_cfg.svh"
module analog_output_channel_failsafe
  import ao_failsafe_pkg::*;
#(
  parameter int WDOG_CYCLES = `WDOG_CYCLES
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // wishbone classic slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // process values from the com unit
  input wire logic pv_valid_in,
  input wire logic [1:0] pv_chan_in,
  input wire logic [15:0] pv_word_in,
  // measured loop current, microamps
  input wire logic cur_valid_in,
  input wire logic [1:0] cur_chan_in,
  input wire logic [15:0] cur_ua_in,
  // per-channel results, channel n in bits 16n+15..16n
  output logic [63:0] out_value_out,
  output logic [63:0] out_status_out,
  output logic [3:0] hart_en_out,
  output logic [3:0] chan_active_out,
  output logic wdog_timeout_out,
  output logic irq_out
);
  logic module_active;
  logic [`CFG_W-1:0] cfg [`NUM_CH];
  word_t sim_val [`NUM_CH];
  word_t subst_val [`NUM_CH];
  word_t lo_lim [`NUM_CH];
  word_t hi_lim [`NUM_CH];
  word_t rng_start [`NUM_CH];
  word_t rng_end [`NUM_CH];
  word_t min_cur [`NUM_CH];
  logic [`STAT_W-1:0] irq_status;
  logic [`STAT_W-1:0] irq_mask;
  logic [`STAT_W-1:0] events;
  logic [`STAT_W-1:0] next_status;
  logic [`NUM_CH-1:0] lb_lvl;
  logic [`NUM_CH-1:0] lb_prev;
  logic [`NUM_CH-1:0] fault_lvl;
  logic [`NUM_CH-1:0] fault_prev;
  logic wdog_expire;
  logic [31:0] next_rdata;
  logic req;
  logic wr;
  logic [2:0] region;
  logic [2:0] idx;
  logic [1:0] ch_sel;
  logic chan_hit;
  logic glob_hit;

  // =====================================================
  // register map: byte address = region * 0x20 + index * 4
  //   0x00 control, bit 0 module active
  //   0x04 status, sticky, cleared by a read
  //        bit 0 watchdog expiry
  //        bits 7:4 lead breakage rise, one per channel
  //        bits 11:8 channel fault rise, one per channel
  //   0x08 interrupt mask, status layout
  //   0x0C live levels, status layout, read only
  //   0x10 to 0x1C output value of channels 0 to 3
  //   channel n starts at 0x20 * (n + 1)
  //     +0x00 config
  //           bit 0 simulation source
  //           bits 2:1 error mode
  //           bit 3 lead breakage check
  //           bit 4 HART on
  //           bit 5 simulated value marked invalid
  //     +0x04 simulation value
  //     +0x08 substitute value
  //     +0x0C lower limit
  //     +0x10 upper limit
  //     +0x14 start of range
  //     +0x18 end of range
  //     +0x1C minimum current, microamps
  //   values sit in data bits 15:0 on lanes 0 and 1
  //   control, mask and config take lane 0 only
  //   address bits 1:0 and lanes 2 and 3 are ignored

  // byte-lane merge for 16-bit registers
  function automatic word_t merge16(input word_t old, input logic [31:0] d,
                                    input logic [3:0] sel);
    merge16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction : merge16

  // =====================================================
  // bus decode: one request is taken per ack
  assign req = wb_cyc_in && wb_stb_in && !wb_ack_out;
  assign wr = req && wb_we_in;
  assign region = wb_adr_in[7:5];
  assign idx = wb_adr_in[4:2];
  assign ch_sel = 2'(region - 3'h1);
  assign glob_hit = region == `REGION_GLOBAL;
  // channel n sits in region n+1
  assign chan_hit = region != `REGION_GLOBAL && region <= 3'(`NUM_CH);

  // ack one cycle after the request is seen, then drop
  // a request still held after ack is taken again once ack drops,
  // so the master must drop cyc and stb after each ack
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      wb_ack_out <= req;
      if (req && !wb_we_in) begin
        wb_dat_out <= next_rdata;
      end
    end
  end

  // =====================================================
  // module-wide control
  // mask bits 11:8 follow lane 0 too, so no split mask write
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      module_active <= `RST_ACTIVE;
      irq_mask <= `STAT_W'(0);
    end else if (wr && glob_hit && wb_sel_in[0]) begin
      if (idx == `IDX_CTRL) begin
        module_active <= wb_dat_in[`CTRL_ACTIVE_BIT];
      end
      if (idx == `IDX_MASK) begin
        irq_mask <= wb_dat_in[`STAT_W-1:0];
      end
    end
  end

  // =====================================================
  // watchdog on the com unit exchange
  // any word restarts it, whatever its channel; the timeout rises
  // CYCLES - 1 edges after the last word and falls on the edge
  // that takes the next one
  ao_comm_watchdog #(
    .CYCLES(WDOG_CYCLES)
  ) u_wdog (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .kick_in(pv_valid_in),
    .timeout_out(wdog_timeout_out),
    .expire_out(wdog_expire)
  );

  // =====================================================
  // per-channel registers and value path
  genvar g;
  generate
    for (g = 0; g < `NUM_CH; g++) begin : g_ch
      logic ch_wr;
      assign ch_wr = wr && chan_hit && ch_sel == 2'(g);

      // software writes; limits and modes take effect next cycle
      // minimum current holds the last index, hence the default
      always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
          cfg[g] <= `RST_CFG;
          sim_val[g] <= `RST_SIM;
          subst_val[g] <= `RST_SUBST;
          lo_lim[g] <= `RST_LO_LIM;
          hi_lim[g] <= `RST_HI_LIM;
          rng_start[g] <= `RST_RNG_START;
          rng_end[g] <= `RST_RNG_END;
          min_cur[g] <= `RST_MIN_CUR;
        end else if (ch_wr) begin
          case (idx)
            `IDX_CFG: begin
              if (wb_sel_in[0]) begin
                cfg[g] <= wb_dat_in[`CFG_W-1:0];
              end
            end
            `IDX_SIM: sim_val[g] <= merge16(sim_val[g], wb_dat_in, wb_sel_in);
            `IDX_SUBST: subst_val[g] <= merge16(subst_val[g], wb_dat_in, wb_sel_in);
            `IDX_LO_LIM: lo_lim[g] <= merge16(lo_lim[g], wb_dat_in, wb_sel_in);
            `IDX_HI_LIM: hi_lim[g] <= merge16(hi_lim[g], wb_dat_in, wb_sel_in);
            `IDX_RNG_START: rng_start[g] <= merge16(rng_start[g], wb_dat_in, wb_sel_in);
            `IDX_RNG_END: rng_end[g] <= merge16(rng_end[g], wb_dat_in, wb_sel_in);
            default: min_cur[g] <= merge16(min_cur[g], wb_dat_in, wb_sel_in);
          endcase
        end
      end

      // a word taken on one edge shows one edge later: that edge
      // latches it, the next one registers the output; an inactive
      // module drives zero on every channel
      ao_channel_path u_path (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .active_in(module_active),
        .timeout_in(wdog_timeout_out),
        .bus_upd_in(pv_valid_in && pv_chan_in == 2'(g)),
        .bus_word_in(pv_word_in),
        .sim_mode_in(cfg[g][`CFG_SIM_BIT]),
        .sim_invalid_in(cfg[g][`CFG_SIMINV_BIT]),
        .sim_value_in(sim_val[g]),
        .err_mode_in(err_mode_e'(cfg[g][`CFG_ERRMODE_LSB +: 2])),
        .subst_in(subst_val[g]),
        .lo_lim_in(lo_lim[g]),
        .hi_lim_in(hi_lim[g]),
        .rng_start_in(rng_start[g]),
        .rng_end_in(rng_end[g]),
        .lbd_en_in(cfg[g][`CFG_LBD_BIT]),
        .min_cur_in(min_cur[g]),
        .cur_valid_in(cur_valid_in && cur_chan_in == 2'(g)),
        .cur_in(cur_ua_in),
        .out_value_out(out_value_out[16*g +: 16]),
        .status_word_out(out_status_out[16*g +: 16]),
        .lead_break_out(lb_lvl[g]),
        .fault_out(fault_lvl[g])
      );

      // a disabled HART channel frees its slot for the others
      always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
          hart_en_out[g] <= 1'b0;
          chan_active_out[g] <= 1'b0;
        end else begin
          hart_en_out[g] <= module_active && cfg[g][`CFG_HART_BIT];
          chan_active_out[g] <= module_active;
        end
      end
    end
  endgenerate

  // =====================================================
  // interrupt events: timeout entry and rising channel flags
  // a level that stays high sets its bit once; it comes back only
  // after the level has fallen and risen again
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      lb_prev <= `NUM_CH'(0);
      fault_prev <= `NUM_CH'(0);
    end else begin
      lb_prev <= lb_lvl;
      fault_prev <= fault_lvl;
    end
  end

  always_comb begin
    events = `STAT_W'(0);
    events[`ST_WDOG_BIT] = wdog_expire;
    events[`ST_LB_LSB +: `NUM_CH] = lb_lvl & ~lb_prev;
    events[`ST_FAULT_LSB +: `NUM_CH] = fault_lvl & ~fault_prev;
    // read clears, but an event in the same cycle still lands
    if (req && !wb_we_in && glob_hit && idx == `IDX_STATUS) begin
      next_status = events;
    end else begin
      next_status = irq_status | events;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      irq_status <= `STAT_W'(0);
      irq_out <= 1'b0;
    end else begin
      irq_status <= next_status;
      irq_out <= |(next_status & irq_mask);
    end
  end

  // =====================================================
  // read mux; unmapped addresses read zero and still ack
  // data is registered on the taking edge so it meets the ack;
  // the price is one cycle of latency on every access, which
  // also keeps this mux out of the bus output path
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (glob_hit) begin
      case (idx)
        `IDX_CTRL: next_rdata[`CTRL_ACTIVE_BIT] = module_active;
        `IDX_STATUS: next_rdata[`STAT_W-1:0] = irq_status;
        `IDX_MASK: next_rdata[`STAT_W-1:0] = irq_mask;
        `IDX_LIVE: begin
          next_rdata[`ST_WDOG_BIT] = wdog_timeout_out;
          next_rdata[`ST_LB_LSB +: `NUM_CH] = lb_lvl;
          next_rdata[`ST_FAULT_LSB +: `NUM_CH] = fault_lvl;
        end
        default: next_rdata[15:0] = out_value_out[16*idx[1:0] +: 16];
      endcase
    end else if (chan_hit) begin
      case (idx)
        `IDX_CFG: next_rdata[`CFG_W-1:0] = cfg[ch_sel];
        `IDX_SIM: next_rdata[15:0] = sim_val[ch_sel];
        `IDX_SUBST: next_rdata[15:0] = subst_val[ch_sel];
        `IDX_LO_LIM: next_rdata[15:0] = lo_lim[ch_sel];
        `IDX_HI_LIM: next_rdata[15:0] = hi_lim[ch_sel];
        `IDX_RNG_START: next_rdata[15:0] = rng_start[ch_sel];
        `IDX_RNG_END: next_rdata[15:0] = rng_end[ch_sel];
        default: next_rdata[15:0] = min_cur[ch_sel];
      endcase
    end
  end
endmodule : analog_output_channel_failsafe
`default_nettype wire

// ---- logic/ao_channel_path.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "ao_failsafe_cfg.svh"
module ao_channel_path
  import ao_failsafe_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic active_in,
  input wire logic timeout_in,
  input wire logic bus_upd_in,
  input wire logic [15:0] bus_word_in,
  input wire logic sim_mode_in,
  input wire logic sim_invalid_in,
  input wire logic [15:0] sim_value_in,
  input wire err_mode_e err_mode_in,
  input wire logic [15:0] subst_in,
  input wire logic [15:0] lo_lim_in,
  input wire logic [15:0] hi_lim_in,
  input wire logic [15:0] rng_start_in,
  input wire logic [15:0] rng_end_in,
  input wire logic lbd_en_in,
  input wire logic [15:0] min_cur_in,
  input wire logic cur_valid_in,
  input wire logic [15:0] cur_in,
  output logic [15:0] out_value_out,
  output logic [15:0] status_word_out,
  output logic lead_break_out,
  output logic fault_out
);
  word_t bus_word;
  word_t last_valid;
  word_t src_value;
  word_t picked;
  word_t clamped;
  logic src_invalid;
  logic fault;
  logic omit;

  // =====================================================
  // latest bus word; low nibble carries the invalid flag
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      bus_word <= 16'h0000;
    end else if (bus_upd_in) begin
      bus_word <= bus_word_in;
    end
  end

  // source select, fault detection, strategy and clamp
  always_comb begin
    if (sim_mode_in) begin
      src_value = sim_value_in;
      src_invalid = sim_invalid_in;
    end else begin
      src_value = {bus_word[15:`PV_STATUS_W], `PV_STATUS_W'(0)};
      src_invalid = bus_word[`PV_INVALID_BIT];
    end
    // line faults stay out of this term on purpose
    fault = timeout_in || src_invalid;
    picked = src_value;
    if (fault) begin
      case (err_mode_in)
        ERR_CURRENT: picked = src_value;
        ERR_SUBST: picked = subst_in;
        ERR_LAST: picked = last_valid;
        default: picked = src_value;
      endcase
    end
    if (picked < lo_lim_in) begin
      clamped = lo_lim_in;
    end else if (picked > hi_lim_in) begin
      clamped = hi_lim_in;
    end else begin
      clamped = picked;
    end
    omit = rng_start_in < `STAT_OMIT_MIN || rng_end_in > `STAT_OMIT_MAX;
  end

  // =====================================================
  // capture only while healthy, so the hold is pre-fault
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      last_valid <= `RST_LO_LIM;
    end else if (!fault) begin
      last_valid <= src_value;
    end
  end

  // lead breakage, refreshed by each current sample
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      lead_break_out <= 1'b0;
    end else if (!lbd_en_in || !active_in) begin
      lead_break_out <= 1'b0;
    end else if (cur_valid_in) begin
      lead_break_out <= cur_in < min_cur_in;
    end
  end

  // =====================================================
  // output and status word; inactive channel drives zero
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      out_value_out <= 16'h0000;
      status_word_out <= 16'h0000;
      fault_out <= 1'b0;
    end else begin
      out_value_out <= active_in ? clamped : 16'h0000;
      fault_out <= active_in && fault;
      if (omit) begin
        status_word_out <= active_in ? clamped : 16'h0000;
      end else begin
        status_word_out <= 16'h0000;
        if (active_in) begin
          status_word_out[15:`PV_STATUS_W] <= clamped[15:`PV_STATUS_W];
          status_word_out[`SW_LINE_FAULT_BIT] <= lead_break_out;
          status_word_out[`SW_FAULT_BIT] <= fault;
        end
      end
    end
  end
endmodule : ao_channel_path
`default_nettype wire

// ---- logic/ao_comm_watchdog.sv ----
`timescale 1ns/1ns
`default_nettype none
module ao_comm_watchdog #(
  parameter int CYCLES = 62500000
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic kick_in,
  output logic timeout_out,
  output logic expire_out
);
  localparam int W = $clog2(CYCLES + 1);
  logic [W-1:0] cnt;

  // =====================================================
  // silence counter, restarted by every exchange
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      cnt <= '0;
    end else if (kick_in) begin
      cnt <= '0;
    end else if (cnt != W'(CYCLES - 1)) begin
      cnt <= cnt + W'(1);
    end
  end

  // =====================================================
  // timeout level plus one pulse on entry
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      timeout_out <= 1'b0;
      expire_out <= 1'b0;
    end else begin
      expire_out <= !kick_in && !timeout_out && cnt == W'(CYCLES - 2);
      if (kick_in) begin
        timeout_out <= 1'b0;
      end else if (cnt == W'(CYCLES - 2)) begin
        timeout_out <= 1'b1;
      end
    end
  end
endmodule : ao_comm_watchdog
`default_nettype wire

// ---- logic/ao_failsafe_cfg.svh ----
`ifndef AO_FAILSAFE_CFG_SVH
`define AO_FAILSAFE_CFG_SVH

// =====================================================
// timing
`define CLK_FREQ_MHZ 125
`define WDOG_TIME_MS 500
`define WDOG_CYCLES (`WDOG_TIME_MS * `CLK_FREQ_MHZ * 1000)

// =====================================================
// register map: region = adr[7:5], index = adr[4:2]
`define NUM_CH 4
`define REGION_GLOBAL 3'h0
`define IDX_CTRL 3'h0
`define IDX_STATUS 3'h1
`define IDX_MASK 3'h2
`define IDX_LIVE 3'h3
`define IDX_CFG 3'h0
`define IDX_SIM 3'h1
`define IDX_SUBST 3'h2
`define IDX_LO_LIM 3'h3
`define IDX_HI_LIM 3'h4
`define IDX_RNG_START 3'h5
`define IDX_RNG_END 3'h6
`define IDX_MIN_CUR 3'h7

// =====================================================
// field positions
`define CTRL_ACTIVE_BIT 0
`define CFG_W 6
`define CFG_SIM_BIT 0
`define CFG_ERRMODE_LSB 1
`define CFG_LBD_BIT 3
`define CFG_HART_BIT 4
`define CFG_SIMINV_BIT 5
`define STAT_W 12
`define ST_WDOG_BIT 0
`define ST_LB_LSB 4
`define ST_FAULT_LSB 8
`define PV_INVALID_BIT 1
`define PV_STATUS_W 4
`define SW_LINE_FAULT_BIT 1
`define SW_FAULT_BIT 3

// =====================================================
// reset values and limits
`define RST_ACTIVE 1'b1
`define RST_CFG 6'h00
`define RST_SIM 16'h2710
`define RST_SUBST 16'h2710
`define RST_LO_LIM 16'h0000
`define RST_HI_LIM 16'hEA60
`define RST_RNG_START 16'h2710
`define RST_RNG_END 16'hC350
`define RST_MIN_CUR 16'h0320
`define STAT_OMIT_MIN 16'h2710
`define STAT_OMIT_MAX 16'hC350

`endif

// ---- logic/ao_failsafe_pkg.sv ----
package ao_failsafe_pkg;
  // error mode, encoded as stored in the channel config field
  typedef enum logic [1:0] {
    ERR_CURRENT = 2'b00,
    ERR_SUBST = 2'b01,
    ERR_LAST = 2'b11
  } err_mode_e;
  typedef logic [15:0] word_t;
endpackage : ao_failsafe_pkg

// ---- verification/ao_com_unit_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module ao_com_unit_model (
  input wire logic clk_sys_in,
  output logic pv_valid_out,
  output logic [1:0] pv_chan_out,
  output logic [15:0] pv_word_out
);
  // idle lines show the inverse of the last word, never a stale copy
  initial begin
    pv_valid_out = 1'b0;
    pv_chan_out = 2'h0;
    pv_word_out = 16'h5A5A;
  end
  // one word per call; the gap between calls sets how slow the unit is
  task send(input logic [1:0] ch, input logic [15:0] w);
    @(posedge clk_sys_in);
    pv_valid_out <= 1'b1;
    pv_chan_out <= ch;
    pv_word_out <= w;
    @(posedge clk_sys_in);
    pv_valid_out <= 1'b0;
    pv_chan_out <= ~ch;
    pv_word_out <= ~w;
  endtask : send
endmodule : ao_com_unit_model
`default_nettype wire

// ---- verification/ao_failsafe_sva.sv ----
`timescale 1ns/1ns
`default_nettype none
module ao_failsafe_sva #(
  parameter int WDOG_CYCLES = 400
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  input wire logic pv_valid_in,
  input wire logic [3:0] hart_en_out,
  input wire logic [3:0] chan_active_out,
  input wire logic wdog_timeout_out
);
  // =====================================================
  // helper: edges since the last process value
  int quiet;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  // saturates so a long silence cannot wrap the count
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) quiet <= 0;
    else if (pv_valid_in) quiet <= 0;
    else if (quiet < WDOG_CYCLES + 8) quiet <= quiet + 1;
  end
  property p_ack_resp;
    wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out;
  endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("no ack after request");
  property p_ack_pulse;
    wb_ack_out |=> !wb_ack_out;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_cause;
    $rose(wb_ack_out) |-> $past(wb_cyc_in && wb_stb_in);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_dat_hold;
    $changed(wb_dat_out) |-> wb_ack_out;
  endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("read data moved without ack");
  property p_active;
    chan_active_out == 4'h0 || chan_active_out == 4'hF;
  endproperty
  a_active: assert property (p_active) else $error("channels differ in active");
  property p_hart;
    (hart_en_out & ~chan_active_out) == 4'h0;
  endproperty
  a_hart: assert property (p_hart) else $error("hart on inactive channel");
  property p_wdog_quiet;
    quiet > 0 && quiet < WDOG_CYCLES - 4 |-> !wdog_timeout_out;
  endproperty
  a_wdog_quiet: assert property (p_wdog_quiet) else $error("early timeout");
  property p_wdog_late;
    quiet > WDOG_CYCLES + 2 |-> wdog_timeout_out;
  endproperty
  a_wdog_late: assert property (p_wdog_late) else $error("missing timeout");
  property p_kick;
    pv_valid_in |-> ##[1:2] !wdog_timeout_out;
  endproperty
  a_kick: assert property (p_kick) else $error("timeout not cleared");
endmodule : ao_failsafe_sva
bind analog_output_channel_failsafe ao_failsafe_sva #(.WDOG_CYCLES(WDOG_CYCLES)) i_sva (
  .clk_sys_in(clk_sys_in), .rst_in(rst_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
  .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .pv_valid_in(pv_valid_in),
  .hart_en_out(hart_en_out), .chan_active_out(chan_active_out),
  .wdog_timeout_out(wdog_timeout_out));
`default_nettype wire

// ---- verification/tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import ao_failsafe_pkg::*;
  localparam int WD = 400;
  logic clk_sys_in, rst_in, wb_cyc, wb_stb, wb_we, wb_ack, pv_valid, cur_valid, wdog_to, irq;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel, hart_en, chan_act;
  logic [31:0] wb_dat, dat_o, rdv, seed;
  logic [1:0] pv_chan, cur_chan;
  logic [15:0] pv_word, cur_ua, e, a;
  logic [63:0] out_val, out_st;
  err_mode_e md[3] = '{ERR_CURRENT, ERR_SUBST, ERR_LAST};
  int error_cnt, n_checks, ch;
  analog_output_channel_failsafe #(.WDOG_CYCLES(WD)) i_analog_output_channel_failsafe (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb),
    .wb_we_in(wb_we), .wb_adr_in(wb_adr), .wb_sel_in(wb_sel), .wb_dat_in(wb_dat),
    .wb_dat_out(dat_o), .wb_ack_out(wb_ack), .pv_valid_in(pv_valid), .pv_chan_in(pv_chan),
    .pv_word_in(pv_word), .cur_valid_in(cur_valid), .cur_chan_in(cur_chan),
    .cur_ua_in(cur_ua), .out_value_out(out_val), .out_status_out(out_st),
    .hart_en_out(hart_en), .chan_active_out(chan_act), .wdog_timeout_out(wdog_to),
    .irq_out(irq));
  ao_com_unit_model i_ao_com_unit_model (.clk_sys_in(clk_sys_in), .pv_valid_out(pv_valid),
    .pv_chan_out(pv_chan), .pv_word_out(pv_word));
  // =====================================================
  // helpers
  task wrap_up;
    $display("errors %0d checks %0d", error_cnt, n_checks);
    if (error_cnt == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  function logic [31:0] rnd;
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function logic [15:0] clampv(logic [15:0] v, logic [15:0] lo, logic [15:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clampv
  function logic [7:0] ra(int c, int idx);
    return 8'((c + 1) * 32 + idx * 4);
  endfunction : ra
  // classic cycle: hold everything until ack is sampled, then release
  task wb(input logic w, input logic [7:0] ad, input logic [15:0] d);
    int i;
    @(posedge clk_sys_in);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= ad;
    wb_dat <= {16'h0000, d};
    wb_sel <= 4'h3;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_sys_in);
      if (wb_ack === 1'b1) break;
    end
    rdv = dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (i == 20) begin
      error_cnt++;
      wrap_up();
    end
  endtask : wb
  task pv(input logic [1:0] c, input logic [15:0] w);
    i_ao_com_unit_model.send(c, w);
    repeat (3) @(posedge clk_sys_in);
  endtask : pv
  task cur(input logic [1:0] c, input logic [15:0] v);
    @(posedge clk_sys_in);
    cur_valid <= 1'b1;
    cur_chan <= c;
    cur_ua <= v;
    @(posedge clk_sys_in);
    cur_valid <= 1'b0;
    cur_ua <= ~v;
    repeat (3) @(posedge clk_sys_in);
  endtask : cur
  initial begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end
  // hang guard well above the longest sequence
  initial begin
    #800000;
    error_cnt++;
    wrap_up();
  end
  // =====================================================
  // main sequence
  initial begin
    {wb_cyc, wb_stb, wb_we, cur_valid} = 4'h0;
    wb_adr = 8'h00;
    wb_sel = 4'h0;
    wb_dat = 32'h0;
    cur_chan = 2'h0;
    cur_ua = 16'h0000;
    seed = 58950;
    rst_in = 1'b1;
    repeat (6) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    chk(chan_act, 4'hF);
    wb(1, 8'hA0, 16'h1234);
    wb(0, 8'hA0, 0); chk(rdv, 0);
    wb(0, ra(0, 1), 0); chk(rdv, 16'h2710);
    wb(0, ra(0, 4), 0); chk(rdv, 16'hEA60);
    wb(0, ra(0, 7), 0); chk(rdv, 16'h0320);
    // normal mode with random words plus the two range ends
    for (int k = 0; k < 10; k++) begin
      a = (k == 0) ? 16'hFFF0 : ((k == 1) ? 16'h0000 : (rnd() & 16'hFFFD));
      ch = k % 4;
      pv(2'(ch), a);
      e = clampv({a[15:4], 4'h0}, 16'h0000, 16'hEA60);
      chk(out_val[16*ch +: 16], e);
      chk(out_st[16*ch +: 16], e);
    end
    wb(1, ra(1, 4), 16'h8000);
    wb(1, ra(1, 3), 16'h3000);
    pv(1, 16'hF000); chk(out_val[31:16], 16'h8000);
    pv(1, 16'h1000); chk(out_val[31:16], 16'h3000);
    wb(1, ra(2, 1), 16'h4567);
    wb(1, ra(2, 0), 16'h0011);
    pv(2, 16'h9990);
    chk(out_val[47:32], 16'h4567);
    chk(out_st[47:32], 16'h4560);
    chk(hart_en, 4'h4);
    wb(1, ra(2, 5), 16'h270F);
    pv(2, 16'h9990); chk(out_st[47:32], 16'h4567);
    // simulated value flagged invalid starts substitution on its own
    wb(1, ra(2, 0), 16'h0033);
    pv(2, 16'h9990); chk(out_val[47:32], 16'h2710);
    // error modes on channel 3, interrupt on its fault bit
    wb(1, ra(3, 2), 16'h4444);
    wb(1, 8'h08, 16'h0800);
    wb(0, 8'h04, 0);
    for (int k = 0; k < 3; k++) begin
      wb(1, ra(3, 0), {13'h0, md[k], 1'b0});
      a = rnd() & 16'h7FF0;
      pv(3, a);
      pv(3, 16'h6662);
      e = (k == 0) ? 16'h6660 : ((k == 1) ? 16'h4444 : a);
      chk(out_val[63:48], e);
      chk(out_st[63:48], {e[15:4], 4'h8});
      chk(irq, 1);
      wb(0, 8'h04, 0); chk(rdv[11:8], 4'h8);
      repeat (2) @(posedge clk_sys_in);
      chk(irq, 0);
    end
    // watchdog expiry then recovery
    wb(1, ra(3, 0), 16'h0002);
    pv(3, 16'h2220);
    repeat (WD + 5) @(posedge clk_sys_in);
    chk(wdog_to, 1);
    chk(out_val[63:48], 16'h4444);
    pv(3, 16'h2220);
    chk(wdog_to, 0);
    chk(out_val[63:48], 16'h2220);
    // expiry plus fault rise on channels 0, 1 and 3; clears the irq
    wb(0, 8'h04, 0); chk(rdv[11:0], 12'hB01);
    // lead breakage on channel 0, masked from the interrupt
    wb(1, ra(0, 0), 16'h0008);
    cur(0, 16'd799);
    chk(out_st[1], 1);
    chk(out_st[3], 0);
    chk(irq, 0);
    cur(0, 16'd800); chk(out_st[1], 0);
    wb(1, ra(0, 0), 16'h0000);
    cur(0, 16'd0); chk(out_st[1], 0);
    wb(1, 8'h00, 16'h0000);
    repeat (2) @(posedge clk_sys_in);
    chk(chan_act, 4'h0);
    chk(hart_en, 4'h0);
    chk(out_val[31:0], 0);
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
